// >>> rpsb_pkg.sv
// package of constants and types for the per-port status and return-path register bank
//
// How it works
// R1: each access goes to the receive port chosen by the port-select register.
// R2: camera error flags load from forward-channel status, never from host writes.
// R3: flag bits 4..0 are ecc, checksum, start, sync, control; bits 7:5 zero.
// R4: a 16-bit parity count restarts on valid lock or on low-byte read.
// R5: reading the low byte also clears the high byte.
// R6: reading the low byte clears the low byte.
// R7: host should disable the parity checker before reading the count.
// R8: a read-only 8-bit self-test error count is provided.
// R9: bit 7 set forwards every local transaction to the serializer.
// R10: bit 6 set forwards only transactions matching the remote address decode.
// R11: bit 5 set makes the device acknowledge all writes itself.
// R12: bit 4 set keeps return path on, else only with a pass-through bit.
// R13: writes to bit 4 are accepted from the local master only.
// R14: bit 3 enables return-path crc generation, reset value one.
// R15: bits 2:0 select return-path rate; reset value from a power-up strap.
// R16: both ends tolerate short return-path errors after a rate change.
// R17: host should enable auto-acknowledge before remote rate changes.
// R18: the parity and self-test counters saturate instead of wrapping.
package rpsb_pkg;
    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [7:0] RPSB_ADDR_FLAGS = 8'h54;
    localparam logic [7:0] RPSB_ADDR_PAR_HI = 8'h55;
    localparam logic [7:0] RPSB_ADDR_PAR_LO = 8'h56;
    localparam logic [7:0] RPSB_ADDR_BIST = 8'h57;
    localparam logic [7:0] RPSB_ADDR_BCC = 8'h58;
    localparam int RPSB_PORTS = 4;
    localparam int RPSB_PSEL_W = 2;
    // ************************************************************
    // field layout and reset values
    // ************************************************************
    localparam int RPSB_BIT_PASS_ALL = 7;
    localparam int RPSB_BIT_PASS_DEC = 6;
    localparam int RPSB_BIT_AUTO_ACK = 5;
    localparam int RPSB_BIT_FORCED_ON = 4;
    localparam int RPSB_BIT_CRC_ON = 3;
    localparam logic [4:0] RPSB_FLAGS_RST = 5'h00;
    localparam logic [15:0] RPSB_PAR_RST = 16'h0000;
    localparam logic [15:0] RPSB_PAR_MAX = 16'hffff;
    localparam logic [7:0] RPSB_BIST_RST = 8'h00;
    localparam logic [7:0] RPSB_BIST_MAX = 8'hff;
    localparam logic [7:0] RPSB_BYTE_ZERO = 8'h00;
    localparam logic [2:0] RPSB_RATE_STRAP_CLR = 3'h0;
    // last strap-window count value, then writes are taken
    localparam logic [1:0] RPSB_STRAP_LAST = 2'h2;
    localparam int RPSB_RATE_MSB = 2;
    localparam logic [2:0] RPSB_FLAGS_PAD = 3'h0;
    // return-path rate codes
    localparam logic [2:0] RPSB_RATE_2M5 = 3'h0;
    localparam logic [2:0] RPSB_RATE_10M = 3'h2;
    localparam logic [2:0] RPSB_RATE_50M = 3'h6;

    // remote camera error flags, packed in register order
    typedef struct packed {
        logic remote_double_ecc_flag;
        logic remote_checksum_flag;
        logic remote_start_tx_flag;
        logic remote_sync_flag;
        logic remote_control_flag;
    } rpsb_flags_t;

    // return-path settings, packed in register order
    typedef struct packed {
        logic pass_all;
        logic pass_decode;
        logic auto_ack;
        logic return_path_forced_on;
        logic return_path_crc_on;
        logic [2:0] return_path_rate;
    } rpsb_bcc_t;

    localparam rpsb_bcc_t RPSB_BCC_RST_BASE = '{pass_all: 1'b0, pass_decode: 1'b0,
        auto_ack: 1'b0, return_path_forced_on: 1'b1, return_path_crc_on: 1'b1,
        return_path_rate: 3'h0};

    // host register access
    typedef struct packed {
        logic rd;
        logic wr;
        logic remote;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rpsb_req_t;

    // per-port link events, same clock
    typedef struct packed {
        logic flags_valid;
        rpsb_flags_t flags;
        logic lock_valid;
        logic parity_err;
        logic bist_clear;
        logic bist_err;
    } rpsb_evt_t;
endpackage

// >>> rpsb_bank.sv
// per-receive-port status, error counters and return-path settings bank
`timescale 1ns/10ps
module rpsb_bank (
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // strap pins for reset rate, asynchronous
    input wire logic [2:0] rate_strap_i,
    // host access
    input wire logic [rpsb_pkg::RPSB_PSEL_W-1:0] port_sel_i,
    input wire rpsb_pkg::rpsb_req_t req_i,
    output logic [7:0] rdata_o,
    output logic hit_o,
    // per-port link events
    input wire rpsb_pkg::rpsb_evt_t [rpsb_pkg::RPSB_PORTS-1:0] evt_i,
    // per-port controls
    output rpsb_pkg::rpsb_bcc_t [rpsb_pkg::RPSB_PORTS-1:0] bcc_o,
    output logic [rpsb_pkg::RPSB_PORTS-1:0] return_path_en_o,
    // per-port transaction forwarding decision
    input wire logic [rpsb_pkg::RPSB_PORTS-1:0] txn_start_i,
    input wire logic [rpsb_pkg::RPSB_PORTS-1:0] txn_addr_match_i,
    output logic [rpsb_pkg::RPSB_PORTS-1:0] txn_forward_o,
    output logic [rpsb_pkg::RPSB_PORTS-1:0] auto_ack_o
);
    import rpsb_pkg::*;

    // ************************************************************
    // strap capture
    // ************************************************************
    logic [2:0] strap_s1_q;
    logic [2:0] strap_s2_q;
    logic strap_done_q;

    // straps are pins, so two flops before use
    always_ff @(posedge clk_i) begin
        strap_s1_q <= rate_strap_i;
        strap_s2_q <= strap_s1_q;
    end

    // the first cycles after reset load the synchronised strap into every port
    logic [1:0] strap_cnt_q;
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            strap_cnt_q <= 2'h0;
            strap_done_q <= 1'b0;
        end else if (!strap_done_q) begin
            strap_cnt_q <= strap_cnt_q + 2'h1;
            strap_done_q <= (strap_cnt_q == RPSB_STRAP_LAST);
        end
    end

    // ************************************************************
    // register state
    // ************************************************************
    rpsb_flags_t flags_q [RPSB_PORTS];
    logic [15:0] par_q [RPSB_PORTS];
    logic [7:0] bist_q [RPSB_PORTS];
    rpsb_bcc_t bcc_q [RPSB_PORTS];

    logic rd_lo [RPSB_PORTS];
    logic wr_bcc [RPSB_PORTS];

    // decode: only the selected port sees the access
    always_comb begin
        for (int p = 0; p < RPSB_PORTS; p++) begin
            rd_lo[p] = req_i.rd && (port_sel_i == RPSB_PSEL_W'(p))
                && (req_i.addr == RPSB_ADDR_PAR_LO); // see R1
            wr_bcc[p] = req_i.wr && (port_sel_i == RPSB_PSEL_W'(p))
                && (req_i.addr == RPSB_ADDR_BCC); // see R1
        end
    end

    // flags follow the forward channel; host writes to 0x54 are ignored
    always_ff @(posedge clk_i) begin
        for (int p = 0; p < RPSB_PORTS; p++) begin
            if (!nrst_i) begin
                flags_q[p] <= rpsb_flags_t'(RPSB_FLAGS_RST);
            end else if (evt_i[p].flags_valid) begin
                flags_q[p] <= evt_i[p].flags; // see R2
            end
        end
    end

    // parity count: lock restarts, low read clears both bytes.
    // an error in the clearing cycle counts as one so it is not lost.
    always_ff @(posedge clk_i) begin
        for (int p = 0; p < RPSB_PORTS; p++) begin
            if (!nrst_i) begin
                par_q[p] <= RPSB_PAR_RST;
            end else if (evt_i[p].lock_valid || rd_lo[p]) begin
                par_q[p] <= {15'h0000, evt_i[p].parity_err}; // see R4 see R5 see R6
            end else if (evt_i[p].parity_err && par_q[p] != RPSB_PAR_MAX) begin
                par_q[p] <= par_q[p] + 16'h0001; // see R18
            end
        end
    end

    // self-test error count, restarted by the self-test logic
    always_ff @(posedge clk_i) begin
        for (int p = 0; p < RPSB_PORTS; p++) begin
            if (!nrst_i || evt_i[p].bist_clear) begin
                bist_q[p] <= RPSB_BIST_RST;
            end else if (evt_i[p].bist_err && bist_q[p] != RPSB_BIST_MAX) begin
                bist_q[p] <= bist_q[p] + 8'h01; // see R8 see R18
            end
        end
    end

    // return-path settings; the forced-on bit ignores remote writes.
    // a rate change glitches traffic briefly, the link logic tolerates it
    always_ff @(posedge clk_i) begin
        for (int p = 0; p < RPSB_PORTS; p++) begin
            if (!nrst_i) begin
                bcc_q[p] <= RPSB_BCC_RST_BASE; // see R14
            end else if (!strap_done_q) begin
                bcc_q[p].return_path_rate <= strap_s2_q; // see R15
            end else if (wr_bcc[p]) begin
                bcc_q[p].pass_all <= req_i.wdata[RPSB_BIT_PASS_ALL];
                bcc_q[p].pass_decode <= req_i.wdata[RPSB_BIT_PASS_DEC];
                bcc_q[p].auto_ack <= req_i.wdata[RPSB_BIT_AUTO_ACK];
                bcc_q[p].return_path_crc_on <= req_i.wdata[RPSB_BIT_CRC_ON]; // see R14
                bcc_q[p].return_path_rate <= req_i.wdata[RPSB_RATE_MSB:0]; // see R15 see R16
                if (!req_i.remote) begin
                    bcc_q[p].return_path_forced_on <= req_i.wdata[RPSB_BIT_FORCED_ON]; // see R13
                end
            end
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    always_comb begin
        for (int p = 0; p < RPSB_PORTS; p++) begin
            bcc_o[p] = bcc_q[p];
            return_path_en_o[p] = bcc_q[p].return_path_forced_on
                || bcc_q[p].pass_all || bcc_q[p].pass_decode; // see R12
            txn_forward_o[p] = txn_start_i[p] && (bcc_q[p].pass_all // see R9
                || (bcc_q[p].pass_decode && txn_addr_match_i[p])); // see R10
            auto_ack_o[p] = bcc_q[p].auto_ack; // see R11 see R17
        end
    end

    // read data registered: valid the cycle after rd
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            rdata_o <= RPSB_BYTE_ZERO;
            hit_o <= 1'b0;
        end else if (req_i.rd) begin
            hit_o <= 1'b1;
            unique case (req_i.addr)
                RPSB_ADDR_FLAGS: rdata_o <= {RPSB_FLAGS_PAD, flags_q[port_sel_i]}; // see R3
                RPSB_ADDR_PAR_HI: rdata_o <= par_q[port_sel_i][15:8];
                RPSB_ADDR_PAR_LO: rdata_o <= par_q[port_sel_i][7:0];
                RPSB_ADDR_BIST: rdata_o <= bist_q[port_sel_i];
                RPSB_ADDR_BCC: rdata_o <= bcc_q[port_sel_i];
                default: begin
                    rdata_o <= RPSB_BYTE_ZERO;
                    hit_o <= 1'b0;
                end
            endcase
        end else begin
            hit_o <= 1'b0;
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    property p_lo_clear;
        @(posedge clk_i) disable iff (!nrst_i)
        (rd_lo[0] && !evt_i[0].parity_err) |=> (par_q[0] == RPSB_PAR_RST);
    endproperty
    a_lo_clear: assert property (p_lo_clear) else $error("low read did not clear count"); // see R5

    property p_count_up;
        @(posedge clk_i) disable iff (!nrst_i)
        (evt_i[0].parity_err && !rd_lo[0] && !evt_i[0].lock_valid && par_q[0] != RPSB_PAR_MAX)
        |=> (par_q[0] == $past(par_q[0]) + 16'h0001);
    endproperty
    a_count_up: assert property (p_count_up) else $error("count not incremented"); // see R4

    property p_sat;
        @(posedge clk_i) disable iff (!nrst_i)
        (par_q[1] == RPSB_PAR_MAX && !rd_lo[1] && !evt_i[1].lock_valid)
        |=> (par_q[1] == RPSB_PAR_MAX);
    endproperty
    a_sat: assert property (p_sat) else $error("parity count wrapped"); // see R18

    property p_remote_keep;
        @(posedge clk_i) disable iff (!nrst_i)
        (wr_bcc[1] && req_i.remote && strap_done_q) |=> $stable(bcc_q[1].return_path_forced_on);
    endproperty
    a_remote_keep: assert property (p_remote_keep) else $error("remote set forced-on"); // see R13

    property p_en;
        @(posedge clk_i) disable iff (!nrst_i)
        (!bcc_q[2].return_path_forced_on && !bcc_q[2].pass_all && !bcc_q[2].pass_decode)
        |-> !return_path_en_o[2];
    endproperty
    a_en: assert property (p_en) else $error("return path on without cause"); // see R12

    property p_fwd;
        @(posedge clk_i) disable iff (!nrst_i)
        (txn_start_i[2] && !txn_addr_match_i[2] && !bcc_q[2].pass_all) |-> !txn_forward_o[2];
    endproperty
    a_fwd: assert property (p_fwd) else $error("unmatched transaction forwarded"); // see R10

    property p_flags;
        @(posedge clk_i) disable iff (!nrst_i)
        evt_i[3].flags_valid |=> (flags_q[3] == $past(evt_i[3].flags));
    endproperty
    a_flags: assert property (p_flags) else $error("flags not loaded"); // see R2

    property p_sel;
        @(posedge clk_i) disable iff (!nrst_i)
        (wr_bcc[2] && strap_done_q) |=> $stable(bcc_q[0]);
    endproperty
    a_sel: assert property (p_sel) else $error("unselected port written"); // see R1

    property p_reserved;
        @(posedge clk_i) disable iff (!nrst_i)
        (req_i.rd && req_i.addr == RPSB_ADDR_FLAGS) |=> (rdata_o[7:5] == 3'h0);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved flag bits set"); // see R3

    // ************************************************************
    // reset, settings, forwarding and counter checks
    // ************************************************************
    // reset is synchronous, so these two run without disable iff
    property p_rst_bcc;
        @(posedge clk_i)
        !nrst_i |=> (bcc_q[0] == RPSB_BCC_RST_BASE);
    endproperty
    a_rst_bcc: assert property (p_rst_bcc) else $error("settings not reset"); // see R14

    property p_rst_out;
        @(posedge clk_i)
        !nrst_i |=> (rdata_o == RPSB_BYTE_ZERO && !hit_o && par_q[1] == RPSB_PAR_RST);
    endproperty
    a_rst_out: assert property (p_rst_out) else $error("outputs not reset"); // see R4

    // the strap is taken again after every reset, not only at power-up
    property p_strap;
        @(posedge clk_i) disable iff (!nrst_i)
        !strap_done_q |=> (bcc_q[0].return_path_rate == $past(strap_s2_q));
    endproperty
    a_strap: assert property (p_strap) else $error("rate not from strap"); // see R15

    // a local write lands whole, forced-on bit included
    property p_local_wr;
        @(posedge clk_i) disable iff (!nrst_i)
        (wr_bcc[1] && !req_i.remote && strap_done_q) |=> (bcc_q[1] == $past(req_i.wdata));
    endproperty
    a_local_wr: assert property (p_local_wr) else $error("local write lost"); // see R13

    property p_rate_wr;
        @(posedge clk_i) disable iff (!nrst_i)
        (wr_bcc[2] && strap_done_q)
        |=> (bcc_o[2].return_path_rate == $past(req_i.wdata[RPSB_RATE_MSB:0]));
    endproperty
    a_rate_wr: assert property (p_rate_wr) else $error("rate not written"); // see R15

    // a remote write still reaches every field except forced-on
    property p_remote_wr;
        @(posedge clk_i) disable iff (!nrst_i)
        (wr_bcc[1] && req_i.remote && strap_done_q)
        |=> (auto_ack_o[1] == $past(req_i.wdata[RPSB_BIT_AUTO_ACK]));
    endproperty
    a_remote_wr: assert property (p_remote_wr) else $error("remote write lost"); // see R11

    property p_auto_ack;
        @(posedge clk_i) disable iff (!nrst_i)
        (wr_bcc[2] && strap_done_q)
        |=> (auto_ack_o[2] == $past(req_i.wdata[RPSB_BIT_AUTO_ACK]));
    endproperty
    a_auto_ack: assert property (p_auto_ack) else $error("auto-ack not written"); // see R11

    property p_crc;
        @(posedge clk_i) disable iff (!nrst_i)
        (wr_bcc[2] && strap_done_q)
        |=> (bcc_o[2].return_path_crc_on == $past(req_i.wdata[RPSB_BIT_CRC_ON]));
    endproperty
    a_crc: assert property (p_crc) else $error("crc enable not written"); // see R14

    // forwarding is gated per transaction start, never free-running
    property p_pass_all;
        @(posedge clk_i) disable iff (!nrst_i)
        (txn_start_i[2] && bcc_q[2].pass_all) |-> txn_forward_o[2];
    endproperty
    a_pass_all: assert property (p_pass_all) else $error("pass-all not forwarded"); // see R9

    property p_idle_fwd;
        @(posedge clk_i) disable iff (!nrst_i)
        !txn_start_i[2] |-> !txn_forward_o[2];
    endproperty
    a_idle_fwd: assert property (p_idle_fwd) else $error("forward with no start"); // see R9

    property p_dec_fwd;
        @(posedge clk_i) disable iff (!nrst_i)
        (txn_start_i[2] && txn_addr_match_i[2] && bcc_q[2].pass_decode)
        |-> txn_forward_o[2];
    endproperty
    a_dec_fwd: assert property (p_dec_fwd) else $error("match not forwarded"); // see R10

    property p_en_on;
        @(posedge clk_i) disable iff (!nrst_i)
        (bcc_q[2].return_path_forced_on || bcc_q[2].pass_all) |-> return_path_en_o[2];
    endproperty
    a_en_on: assert property (p_en_on) else $error("return path off"); // see R12

    // a read of either byte shows the count as it stood before any clear
    property p_lock;
        @(posedge clk_i) disable iff (!nrst_i)
        (evt_i[0].lock_valid && !evt_i[0].parity_err) |=> (par_q[0] == RPSB_PAR_RST);
    endproperty
    a_lock: assert property (p_lock) else $error("lock did not restart"); // see R4

    property p_lo_data;
        @(posedge clk_i) disable iff (!nrst_i)
        rd_lo[0] |=> (rdata_o == $past(par_q[0][7:0]));
    endproperty
    a_lo_data: assert property (p_lo_data) else $error("low byte wrong"); // see R6

    property p_hi_data;
        @(posedge clk_i) disable iff (!nrst_i)
        (req_i.rd && port_sel_i == 2'h0 && req_i.addr == RPSB_ADDR_PAR_HI)
        |=> (rdata_o == $past(par_q[0][15:8]));
    endproperty
    a_hi_data: assert property (p_hi_data) else $error("high byte wrong"); // see R4

    // the self-test count saturates so a long run never reads back small
    property p_bist_up;
        @(posedge clk_i) disable iff (!nrst_i)
        (evt_i[3].bist_err && !evt_i[3].bist_clear && bist_q[3] != RPSB_BIST_MAX)
        |=> (bist_q[3] == $past(bist_q[3]) + 8'h01);
    endproperty
    a_bist_up: assert property (p_bist_up) else $error("bist not counted"); // see R8

    property p_bist_sat;
        @(posedge clk_i) disable iff (!nrst_i)
        (bist_q[3] == RPSB_BIST_MAX && !evt_i[3].bist_clear) |=> (bist_q[3] == RPSB_BIST_MAX);
    endproperty
    a_bist_sat: assert property (p_bist_sat) else $error("bist count wrapped"); // see R18

    property p_bist_clr;
        @(posedge clk_i) disable iff (!nrst_i)
        evt_i[3].bist_clear |=> (bist_q[3] == RPSB_BIST_RST);
    endproperty
    a_bist_clr: assert property (p_bist_clr) else $error("bist not cleared"); // see R8

    property p_hit;
        @(posedge clk_i) disable iff (!nrst_i)
        (req_i.rd && req_i.addr >= RPSB_ADDR_FLAGS && req_i.addr <= RPSB_ADDR_BCC)
        |=> hit_o;
    endproperty
    a_hit: assert property (p_hit) else $error("mapped read not hit"); // see R1

    c_lo_read: cover property (@(posedge clk_i) rd_lo[0] && par_q[0] != RPSB_PAR_RST);
    c_sat: cover property (@(posedge clk_i) par_q[1] == RPSB_PAR_MAX);
    c_remote_wr: cover property (@(posedge clk_i) wr_bcc[1] && req_i.remote);
    c_fwd: cover property (@(posedge clk_i) txn_forward_o[2]);
    c_bist_sat: cover property (@(posedge clk_i) bist_q[3] == RPSB_BIST_MAX);
endmodule

// >>> rpsb_ser_model.sv
// behavioural remote serializer that raises per-port link events
`timescale 1ns/10ps
module rpsb_ser_model (
    // clock
    input wire logic clk_i,
    // event request from the bench
    input wire logic [2:0] kind_i,
    input wire logic [1:0] port_i,
    input wire rpsb_pkg::rpsb_flags_t flags_i,
    // link events toward the hub
    output rpsb_pkg::rpsb_evt_t [rpsb_pkg::RPSB_PORTS-1:0] evt_o
);
    import rpsb_pkg::*;
    // one pulse per cycle a kind is held; all other ports and kinds sit low
    // a rate change never raises an error here, short upsets are tolerated
    always_ff @(posedge clk_i) begin
        evt_o <= '0;
        evt_o[port_i].flags_valid <= (kind_i == 3'h1);
        evt_o[port_i].flags <= flags_i;
        evt_o[port_i].parity_err <= (kind_i == 3'h2);
        evt_o[port_i].lock_valid <= (kind_i == 3'h3);
        evt_o[port_i].bist_err <= (kind_i == 3'h4);
        evt_o[port_i].bist_clear <= (kind_i == 3'h5);
    end
endmodule

// >>> testbench.sv
// self-checking bench for the per-port status and return-path bank
`timescale 1ns/10ps
module testbench;
    import rpsb_pkg::*;
    typedef struct packed {
        logic rd; logic wr; logic rm; logic [1:0] p;
        logic [7:0] a; logic [7:0] d; logic [7:0] e;
    } rpsb_tbrow_t;
    // ************************************************************
    // signals
    // ************************************************************
    logic clk_i = 1'b0;
    logic nrst = 1'b0;
    logic [2:0] strap = 3'h6;
    logic [1:0] port_sel = 2'h0;
    rpsb_req_t req = '0;
    logic [7:0] rdata_o;
    logic hit_o;
    rpsb_evt_t [RPSB_PORTS-1:0] evt;
    rpsb_bcc_t [RPSB_PORTS-1:0] bcc_o;
    logic [3:0] return_path_en_o, txn_forward_o, auto_ack_o;
    logic [3:0] start = 4'h0;
    logic [3:0] match = 4'h0;
    logic [2:0] kind = 3'h0;
    logic [1:0] eport = 2'h0;
    rpsb_flags_t flags = '0;
    int failures = 0;
    int checked = 0;
    logic [7:0] v;
    rpsb_tbrow_t rows [17] = '{
        '{1'b1, 1'b0, 1'b0, 2'h0, 8'h58, 8'h00, 8'h1e},
        '{1'b1, 1'b0, 1'b0, 2'h0, 8'h54, 8'h00, 8'h00},
        '{1'b1, 1'b0, 1'b0, 2'h0, 8'h55, 8'h00, 8'h00},
        '{1'b1, 1'b0, 1'b0, 2'h0, 8'h56, 8'h00, 8'h00},
        '{1'b1, 1'b0, 1'b0, 2'h0, 8'h57, 8'h00, 8'h00},
        '{1'b1, 1'b0, 1'b0, 2'h0, 8'h53, 8'h00, 8'h00},
        '{1'b0, 1'b1, 1'b0, 2'h1, 8'h58, 8'hef, 8'h00},
        '{1'b1, 1'b0, 1'b0, 2'h1, 8'h58, 8'h00, 8'hef},
        '{1'b0, 1'b1, 1'b1, 2'h1, 8'h58, 8'h12, 8'h00}, // auto-ack already on
        '{1'b1, 1'b0, 1'b0, 2'h1, 8'h58, 8'h00, 8'h02},
        '{1'b0, 1'b1, 1'b0, 2'h1, 8'h54, 8'hff, 8'h00},
        '{1'b1, 1'b0, 1'b0, 2'h1, 8'h54, 8'h00, 8'h00},
        '{1'b0, 1'b1, 1'b0, 2'h2, 8'h58, 8'h02, 8'h00},
        '{1'b1, 1'b0, 1'b0, 2'h2, 8'h58, 8'h00, 8'h02},
        '{1'b0, 1'b1, 1'b0, 2'h2, 8'h58, 8'h06, 8'h00},
        '{1'b1, 1'b0, 1'b0, 2'h2, 8'h58, 8'h00, 8'h06},
        '{1'b1, 1'b0, 1'b0, 2'h0, 8'h58, 8'h00, 8'h1e}};
    logic [7:0] cfgs [5] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h00};
    // ************************************************************
    // instances and clock
    // ************************************************************
    rpsb_bank dut (.clk_i(clk_i), .nrst_i(nrst), .rate_strap_i(strap), .port_sel_i(port_sel),
        .req_i(req), .rdata_o(rdata_o), .hit_o(hit_o), .evt_i(evt), .bcc_o(bcc_o),
        .return_path_en_o(return_path_en_o), .txn_start_i(start),
        .txn_addr_match_i(match), .txn_forward_o(txn_forward_o), .auto_ack_o(auto_ack_o));
    rpsb_ser_model ser (.clk_i(clk_i), .kind_i(kind), .port_i(eport), .flags_i(flags),
        .evt_o(evt));
    // 25 MHz clock
    initial begin
        forever #20 clk_i = ~clk_i;
    end
    // ************************************************************
    // tasks
    // ************************************************************
    // one register access, answer sampled mid-cycle after the taking edge
    task automatic acc(input logic r, w, m, input logic [1:0] p, input logic [7:0] a, d);
        @(negedge clk_i);
        port_sel = p;
        req = '{rd: r, wr: w, remote: m, addr: a, wdata: d};
        @(negedge clk_i);
        req = '0;
    endtask
    task automatic chk(input logic [7:0] g, e);
        checked++;
        if (g !== e) begin
            failures++;
            $display("wrong value at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic rd_chk(input logic [1:0] p, input logic [7:0] a, e);
        acc(1'b1, 1'b0, 1'b0, p, a, 8'h00);
        chk(rdata_o, e);
    endtask
    // hold an event kind for n cycles, giving n back-to-back pulses
    task automatic ev(input logic [2:0] k, input logic [1:0] p, input int n);
        @(negedge clk_i);
        kind = k;
        eport = p;
        repeat (n) @(negedge clk_i);
        kind = 3'h0;
    endtask
    task automatic give_verdict;
        $display("checks %0d, failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // ************************************************************
    // tests
    // ************************************************************
    initial begin
        repeat (10) @(negedge clk_i);
        nrst = 1'b1;
        repeat (4) @(negedge clk_i);
        for (int i = 0; i < 17; i++) begin
            acc(rows[i].rd, rows[i].wr, rows[i].rm, rows[i].p, rows[i].a, rows[i].d);
            if (rows[i].rd) begin
                chk(rdata_o, rows[i].e);
                chk({7'h0, hit_o}, {7'h0, (rows[i].a inside {[8'h54:8'h58]})});
            end
        end
        $display("test table done");
        flags = 5'h15;
        ev(3'h1, 2'h3, 1);
        rd_chk(2'h3, 8'h54, 8'h15);
        rd_chk(2'h0, 8'h54, 8'h00);
        $display("test flags done");
        // event traffic stops before the count is read
        ev(3'h2, 2'h0, 300);
        rd_chk(2'h0, 8'h55, 8'h01);
        rd_chk(2'h0, 8'h56, 8'h2c);
        rd_chk(2'h0, 8'h55, 8'h00);
        rd_chk(2'h0, 8'h56, 8'h00);
        ev(3'h2, 2'h0, 5);
        ev(3'h3, 2'h0, 1);
        rd_chk(2'h0, 8'h56, 8'h00);
        ev(3'h2, 2'h1, 65537);
        rd_chk(2'h1, 8'h55, 8'hff);
        rd_chk(2'h1, 8'h56, 8'hff);
        ev(3'h4, 2'h3, 257);
        rd_chk(2'h3, 8'h57, 8'hff);
        ev(3'h5, 2'h3, 1);
        rd_chk(2'h3, 8'h57, 8'h00);
        $display("test counters done");
        foreach (cfgs[i]) begin
            v = cfgs[i];
            acc(1'b0, 1'b1, 1'b0, 2'h2, 8'h58, v);
            chk(bcc_o[2], v);
            for (int m = 0; m < 2; m++) begin
                @(negedge clk_i);
                match = {4{m[0]}};
                start = 4'h4;
                #1;
                chk({5'h0, txn_forward_o[2], return_path_en_o[2], auto_ack_o[2]},
                    {5'h0, v[7] | (v[6] & m[0]), v[4] | v[7] | v[6], v[5]});
            end
            start = 4'h0;
        end
        $display("test forwarding done");
        strap = 3'h2;
        nrst = 1'b0;
        repeat (2) @(negedge clk_i);
        nrst = 1'b1;
        repeat (4) @(negedge clk_i);
        rd_chk(2'h2, 8'h58, 8'h1a);
        $display("test second reset done");
        give_verdict();
    end
    // watchdog, well past the expected run of about 66200 cycles
    initial begin
        repeat (80000) @(posedge clk_i);
        failures++;
        give_verdict();
    end
endmodule
